// *** verilog/tape_port_params.svh ***
// Constants shared by both ends of the tape controller message port
`ifndef TAPE_PORT_PARAMS_SVH
`define TAPE_PORT_PARAMS_SVH
// =====================================
// Timing
`define CLK_PERIOD_NS  10
`define BYTE_PERIOD_NS 3900
`define BYTE_CYCLES    (`BYTE_PERIOD_NS / `CLK_PERIOD_NS)
`define INT_CYCLES     2
// =====================================
// Sizes and address match field
`define MSG_BYTES      256
`define REC_BYTES      2048
`define SEL_HI         15
`define SEL_LO         8
// =====================================
// Message layout and message types
`define MSG_TYPE_IDX   0
`define MSG_CNT_IDX    1
`define MSG_PAY_IDX    2
`define MSG_DATA       8'h00
`define MSG_END_REC    8'h01
`define MSG_XFER       8'h02
// =====================================
// Host controller registers
`define REG_STATUS     8'h00
`define REG_TARGET     8'h04
`define REG_TXDATA     8'h08
`define REG_RXDATA     8'h0c
`define REG_INT_STAT   8'h10
`define REG_INT_MASK   8'h14
`define STAT_RECV_BIT  0
`define STAT_SEND_BIT  1
`define TARGET_RST     16'h0000
`endif

// *** verilog/tape_port_pkg.sv ***
// Types shared by both ends of the tape controller message port
package tape_port_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  typedef enum logic [2:0] {
    ENG_RECV    = 3'b000,
    ENG_DECODE  = 3'b001,
    ENG_TAPE_WR = 3'b010,
    ENG_TAPE_RD = 3'b011,
    ENG_SEND    = 3'b100
  } eng_state_t;
  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_CYCLE = 2'b01,
    HS_ACK   = 2'b10
  } hs_state_t;
  typedef enum logic [1:0] {
    HL_IDLE    = 2'b00,
    HL_WAIT    = 2'b01,
    HL_STROBE  = 2'b10,
    HL_RELEASE = 2'b11
  } link_state_t;
endpackage

// *** verilog/io_bus_if.sv ***
// Parallel common bus between the host controller and the tape card
interface io_bus_if;
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] addr;
  logic [7:0]  host_data;
  logic        host_data_oe;
  logic [7:0]  card_data;
  logic        card_data_oe;
  logic        wr_strobe;
  logic        rd_strobe;
  logic        byte_valid_ack;
  logic        recv_ready;
  logic        send_ready;
  logic [7:0]  data_bus;

  // Resolved level of the shared data lines
  assign data_bus = card_data_oe ? card_data : (host_data_oe ? host_data : 8'h00);

  modport card (
    input  addr, data_bus, host_data_oe, wr_strobe, rd_strobe,
    output card_data, card_data_oe, byte_valid_ack, recv_ready, send_ready
  );
  modport host (
    input  data_bus, card_data_oe, byte_valid_ack, recv_ready, send_ready,
    output addr, host_data, host_data_oe, wr_strobe, rd_strobe
  );
endinterface

// *** verilog/record_ram.sv ***
// Single-port record memory with one cycle read latency
module record_ram #(
  parameter int DEPTH = 2048,
  parameter int AW    = 11,
  parameter int DW    = 8
) (
  input  wire logic          clk_sys,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// *** verilog/tape_controller_card.sv ***
// Tape card end of the message port: bus handshake, message decode, record memory
`include "tape_port_params.svh"

module tape_controller_card #(
  parameter int REC_BYTES  = `REC_BYTES,
  parameter int MSG_BYTES  = `MSG_BYTES,
  parameter int INT_CYCLES = `INT_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  io_bus_if.card          bus,
  input  wire logic [7:0] card_strap,
  output logic            tape_wr_valid,
  output logic [8:0]      tape_wr_data,
  output logic            tape_wr_last,
  input  wire logic       tape_wr_ready,
  input  wire logic       tape_rd_valid,
  input  wire logic [7:0] tape_rd_data,
  input  wire logic       tape_rd_last,
  output logic            tape_rd_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RAW = $clog2(REC_BYTES);
  localparam int MAW = $clog2(MSG_BYTES);
  tape_port_pkg::eng_state_t eng;
  tape_port_pkg::hs_state_t  hs;
  logic [7:0]   msg_buf [MSG_BYTES];
  logic [MAW-1:0] msg_cnt;
  logic [MAW-1:0] blk_cnt;
  logic [MAW:0]   dec_idx;
  logic [RAW:0]   rec_len;
  logic [RAW:0]   ptr;
  logic [3:0]     cyc_cnt;
  logic           cyc_wr;
  logic           rd_pend;
  logic           ram_we;
  logic [RAW-1:0] ram_addr;
  logic [7:0]     ram_wdata;
  logic [7:0]     ram_rdata;
  logic           hit;
  logic           strobes_low;
  logic           cycle_done;
  logic [7:0]     msg_type;
  logic           dec_more;
  logic           rec_room;

  // =====================================
  // Bus handshake
  // strap address compare
  assign hit         = bus.addr[`SEL_HI:`SEL_LO] == card_strap;
  assign strobes_low = !bus.wr_strobe && !bus.rd_strobe;
  assign cycle_done  = (hs == tape_port_pkg::HS_CYCLE) && (cyc_cnt == 4'(INT_CYCLES - 1));

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hs      <= tape_port_pkg::HS_IDLE;
      cyc_cnt <= 4'h0;
      cyc_wr  <= 1'b0;
    end else begin
      case (hs)
        tape_port_pkg::HS_IDLE: begin
          cyc_cnt <= 4'h0;
          if (hit && bus.wr_strobe && eng == tape_port_pkg::ENG_RECV) begin
            hs     <= tape_port_pkg::HS_CYCLE;
            cyc_wr <= 1'b1;
          end else if (hit && bus.rd_strobe && eng == tape_port_pkg::ENG_SEND) begin
            hs     <= tape_port_pkg::HS_CYCLE;
            cyc_wr <= 1'b0;
          end
        end
        tape_port_pkg::HS_CYCLE: begin
          cyc_cnt <= cyc_cnt + 4'h1;
          if (cycle_done) hs <= tape_port_pkg::HS_ACK;
        end
        tape_port_pkg::HS_ACK: begin
          if (strobes_low) hs <= tape_port_pkg::HS_IDLE;
        end
        default: hs <= tape_port_pkg::HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus.byte_valid_ack <= 1'b0;
      bus.card_data_oe   <= 1'b0;
      bus.card_data      <= 8'h00;
    end else if (cycle_done) begin
      bus.byte_valid_ack <= 1'b1;
      bus.card_data_oe   <= !cyc_wr;
      bus.card_data      <= (!cyc_wr && ptr < rec_len) ? ram_rdata : 8'h00;
    end else if (hs == tape_port_pkg::HS_ACK && strobes_low) begin
      bus.byte_valid_ack <= 1'b0;
      bus.card_data_oe   <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (cycle_done && cyc_wr) msg_buf[msg_cnt] <= bus.data_bus;
  end

  // =====================================
  // Record memory access
  assign msg_type = msg_buf[`MSG_TYPE_IDX];
  assign dec_more = (dec_idx < (MAW+1)'(`MSG_PAY_IDX) + {1'b0, msg_buf[`MSG_CNT_IDX]})
                    && (dec_idx < (MAW+1)'(MSG_BYTES));
  assign rec_room = rec_len < (RAW+1)'(REC_BYTES);

  always_comb begin
    ram_we    = 1'b0;
    ram_wdata = tape_rd_data;
    if (eng == tape_port_pkg::ENG_DECODE && msg_type == `MSG_DATA && dec_more && rec_room) begin
      ram_we    = 1'b1;
      ram_wdata = msg_buf[dec_idx[MAW-1:0]];
    end else if (eng == tape_port_pkg::ENG_TAPE_RD && tape_rd_valid && tape_rd_ready
                 && rec_room) begin
      ram_we = 1'b1;
    end
    ram_addr = ram_we ? rec_len[RAW-1:0] : ptr[RAW-1:0];
  end

  record_ram #(
    .DEPTH (REC_BYTES),
    .AW    (RAW),
    .DW    (8)
  ) i_record_ram (
    .clk_sys (clk_sys),
    .we      (ram_we),
    .addr    (ram_addr),
    .wdata   (ram_wdata),
    .rdata   (ram_rdata)
  );

  // =====================================
  // Message and record engine
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      eng            <= tape_port_pkg::ENG_RECV;
      bus.recv_ready <= 1'b0;
      bus.send_ready <= 1'b0;
      tape_rd_ready  <= 1'b0;
      msg_cnt        <= '0;
      blk_cnt        <= '0;
      dec_idx        <= '0;
      rec_len        <= '0;
      ptr            <= '0;
    end else begin
      case (eng)
        tape_port_pkg::ENG_RECV: begin
          bus.recv_ready <= 1'b1;
          if (cycle_done && cyc_wr) begin
            msg_cnt <= msg_cnt + 1'b1;
            if (msg_cnt == MAW'(MSG_BYTES - 1)) begin
              bus.recv_ready <= 1'b0;
              dec_idx        <= (MAW+1)'(`MSG_PAY_IDX);
              eng            <= tape_port_pkg::ENG_DECODE;
            end
          end
        end
        tape_port_pkg::ENG_DECODE: begin
          if (msg_type == `MSG_DATA) begin
            if (dec_more) begin
              dec_idx <= dec_idx + 1'b1;
              if (rec_room) rec_len <= rec_len + 1'b1;
            end else begin
              eng <= tape_port_pkg::ENG_RECV;
            end
          end else if (msg_type == `MSG_END_REC) begin
            ptr <= '0;
            eng <= (rec_len != '0) ? tape_port_pkg::ENG_TAPE_WR : tape_port_pkg::ENG_RECV;
          end else if (msg_type == `MSG_XFER) begin
            rec_len       <= '0;
            tape_rd_ready <= 1'b1;
            eng           <= tape_port_pkg::ENG_TAPE_RD;
          end else begin
            eng <= tape_port_pkg::ENG_RECV;
          end
        end
        tape_port_pkg::ENG_TAPE_WR: begin
          if (rd_pend) ptr <= ptr + 1'b1;
          if (tape_wr_valid && tape_wr_ready && tape_wr_last) begin
            rec_len <= '0;
            eng     <= tape_port_pkg::ENG_RECV;
          end
        end
        tape_port_pkg::ENG_TAPE_RD: begin
          if (tape_rd_valid) begin
            if (rec_room) rec_len <= rec_len + 1'b1;
            if (tape_rd_last) begin
              tape_rd_ready  <= 1'b0;
              bus.send_ready <= 1'b1;
              ptr            <= '0;
              blk_cnt        <= '0;
              eng            <= tape_port_pkg::ENG_SEND;
            end
          end
        end
        tape_port_pkg::ENG_SEND: begin
          if (cycle_done && !cyc_wr) begin
            bus.send_ready <= 1'b0;
            ptr            <= ptr + 1'b1;
            blk_cnt        <= blk_cnt + 1'b1;
            if (blk_cnt == MAW'(MSG_BYTES - 1)) begin
              if (ptr + 1'b1 >= rec_len) begin
                rec_len <= '0;
                eng     <= tape_port_pkg::ENG_RECV;
              end else begin
                bus.send_ready <= 1'b1;
              end
            end
          end
        end
        default: eng <= tape_port_pkg::ENG_RECV;
      endcase
    end
  end

  // =====================================
  // Tape writer: odd parity forms the ninth track
  // record streamed to tape
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tape_wr_valid <= 1'b0;
      tape_wr_data  <= 9'h000;
      tape_wr_last  <= 1'b0;
      rd_pend       <= 1'b0;
    end else if (eng == tape_port_pkg::ENG_TAPE_WR) begin
      rd_pend <= !tape_wr_valid && !rd_pend && (ptr < rec_len);
      if (rd_pend) begin
        tape_wr_valid <= 1'b1;
        tape_wr_data  <= {~^ram_rdata, ram_rdata};
        tape_wr_last  <= (ptr + 1'b1 == rec_len);
      end else if (tape_wr_valid && tape_wr_ready) begin
        tape_wr_valid <= 1'b0;
        tape_wr_last  <= 1'b0;
      end
    end else begin
      tape_wr_valid <= 1'b0;
      tape_wr_last  <= 1'b0;
      rd_pend       <= 1'b0;
    end
  end
endmodule

// *** verilog/io_controller_host.sv ***
// Host controller end: APB registers drive byte transfers on the common bus
`include "tape_port_params.svh"

module io_controller_host #(
  parameter int BYTE_CYCLES = `BYTE_CYCLES,
  parameter int MSG_BYTES   = `MSG_BYTES
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  io_bus_if.host           bus,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GW  = $clog2(BYTE_CYCLES + 1);
  localparam int MAW = $clog2(MSG_BYTES);

  tape_port_pkg::link_state_t ls;
  logic [15:0]    target;
  logic [1:0]     int_stat;
  logic [1:0]     int_mask;
  logic [1:0]     flags_q;
  logic [GW-1:0]  gap;
  logic [MAW-1:0] tx_cnt;
  logic [MAW-1:0] rx_cnt;
  logic [7:0]     rx_byte;
  logic           op_wr;
  logic           link_done;
  logic           acc;
  logic           go;
  logic [1:0]     flags;

  function automatic logic is_reg(input logic [7:0] a);
    return a == `REG_STATUS || a == `REG_TARGET || a == `REG_TXDATA ||
           a == `REG_RXDATA || a == `REG_INT_STAT || a == `REG_INT_MASK;
  endfunction

  assign acc       = psel && penable && !pready;
  assign flags     = {bus.send_ready, bus.recv_ready};
  assign link_done = (ls == tape_port_pkg::HL_RELEASE) && !bus.byte_valid_ack;
  assign go = op_wr ? (gap == '0 && (tx_cnt != '0 || bus.recv_ready))
                    : (rx_cnt != '0 || bus.send_ready);

  // =====================================
  // Link sequencer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ls               <= tape_port_pkg::HL_IDLE;
      op_wr            <= 1'b0;
      bus.addr         <= 16'h0000;
      bus.host_data    <= 8'h00;
      bus.host_data_oe <= 1'b0;
      bus.wr_strobe    <= 1'b0;
      bus.rd_strobe    <= 1'b0;
      rx_byte          <= 8'h00;
      tx_cnt           <= '0;
      rx_cnt           <= '0;
    end else begin
      case (ls)
        tape_port_pkg::HL_IDLE: begin
          if (acc && is_reg(paddr) &&
              ((pwrite && paddr == `REG_TXDATA) || (!pwrite && paddr == `REG_RXDATA))) begin
            op_wr         <= pwrite;
            bus.addr      <= target;
            bus.host_data <= pwdata[7:0];
            ls            <= tape_port_pkg::HL_WAIT;
          end
        end
        tape_port_pkg::HL_WAIT: begin
          if (go) begin
            bus.wr_strobe    <= op_wr;
            bus.rd_strobe    <= !op_wr;
            bus.host_data_oe <= op_wr;
            ls               <= tape_port_pkg::HL_STROBE;
          end
        end
        tape_port_pkg::HL_STROBE: begin
          if (bus.byte_valid_ack) begin
            rx_byte          <= bus.data_bus;
            bus.wr_strobe    <= 1'b0;
            bus.rd_strobe    <= 1'b0;
            bus.host_data_oe <= 1'b0;
            ls               <= tape_port_pkg::HL_RELEASE;
          end
        end
        tape_port_pkg::HL_RELEASE: begin
          // next byte only after ack drops
          if (!bus.byte_valid_ack) begin
            tx_cnt <= op_wr ? tx_cnt + 1'b1 : tx_cnt;
            rx_cnt <= op_wr ? rx_cnt : rx_cnt + 1'b1;
            ls     <= tape_port_pkg::HL_IDLE;
          end
        end
        default: ls <= tape_port_pkg::HL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gap <= '0;
    end else if (ls == tape_port_pkg::HL_WAIT && go && op_wr) begin
      gap <= GW'(BYTE_CYCLES - 1);
    end else if (gap != '0) begin
      gap <= gap - 1'b1;
    end
  end

  // =====================================
  // APB slave and registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
      target   <= `TARGET_RST;
      int_mask <= 2'b00;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (link_done) begin
        pready <= 1'b1;
        prdata <= op_wr ? 32'h0000_0000 : {24'h00_0000, rx_byte};
      end else if (acc && !((pwrite && paddr == `REG_TXDATA) ||
                            (!pwrite && paddr == `REG_RXDATA))) begin
        pready  <= 1'b1;
        pslverr <= !is_reg(paddr);
        prdata  <= 32'h0000_0000;
        if (pwrite && paddr == `REG_TARGET) begin
          target <= pwdata[15:0];
        end
        if (pwrite && paddr == `REG_INT_MASK) begin
          int_mask <= pwdata[1:0];
        end
        if (!pwrite && paddr == `REG_STATUS) begin
          prdata <= {30'h0000_0000, flags};
        end
        if (!pwrite && paddr == `REG_TARGET) begin
          prdata <= {16'h0000, target};
        end
        if (!pwrite && paddr == `REG_INT_STAT) begin
          prdata <= {30'h0000_0000, int_stat};
        end
        if (!pwrite && paddr == `REG_INT_MASK) begin
          prdata <= {30'h0000_0000, int_mask};
        end
      end
    end
  end

  // =====================================
  // Interrupts: flag rising edges, write one to clear, set wins
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_q  <= 2'b00;
      int_stat <= 2'b00;
      irq      <= 1'b0;
    end else begin
      flags_q  <= flags;
      int_stat <= (int_stat & ~((acc && pwrite && paddr == `REG_INT_STAT) ? pwdata[1:0] : 2'b00))
                  | (flags & ~flags_q);
      irq      <= |(int_stat & int_mask);
    end
  end
endmodule

// *** bench/tape_port_chk.sv ***
// Checker for the common bus between the host controller and the tape card
module tape_port_chk #(
  parameter int INT_CYCLES = 2
) (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [15:0] addr,
  input wire logic [7:0]  card_strap,
  input wire logic        host_data_oe,
  input wire logic        card_data_oe,
  input wire logic        wr_strobe,
  input wire logic        rd_strobe,
  input wire logic        byte_valid_ack,
  input wire logic        recv_ready,
  input wire logic        send_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic strb;
  assign strb = wr_strobe | rd_strobe;
  // ==========================================
  // Bus handshake
  sequence s_ack_drop;
    ##[1:3] !byte_valid_ack;
  endsequence
  sequence s_recv_up;
    ##[1:3] recv_ready;
  endsequence
  property p_ack_match;
    byte_valid_ack |-> addr[15:8] == card_strap;
  endproperty
  property p_ack_cause;
    $rose(byte_valid_ack) |-> $past(strb, 1) && $past(strb, 2) && $past(strb, INT_CYCLES + 1);
  endproperty
  property p_ack_hold;
    byte_valid_ack && strb |=> byte_valid_ack;
  endproperty
  property p_ack_release;
    byte_valid_ack && !strb |-> s_ack_drop;
  endproperty
  property p_rd_drive;
    byte_valid_ack && rd_strobe |-> card_data_oe;
  endproperty
  property p_one_driver;
    card_data_oe |-> !host_data_oe;
  endproperty
  // ==========================================
  // Flags and reset
  property p_flags;
    !(recv_ready && send_ready);
  endproperty
  property p_reset;
    disable iff (1'b0) sys_rst |=> !recv_ready && !send_ready && !byte_valid_ack;
  endproperty
  property p_recv_up;
    $fell(sys_rst) |-> s_recv_up;
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("ack without address match");
  a_ack_cause: assert property (p_ack_cause) else $error("ack not after cycle");
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
  a_ack_release: assert property (p_ack_release) else $error("ack held too long");
  a_rd_drive: assert property (p_rd_drive) else $error("read byte not driven");
  a_one_driver: assert property (p_one_driver) else $error("data lines contended");
  a_flags: assert property (p_flags) else $error("both ready flags high");
  a_reset: assert property (p_reset) else $error("flags not cleared by reset");
  a_recv_up: assert property (p_recv_up) else $error("receive ready late");
  c_read: cover property (rd_strobe && byte_valid_ack);
endmodule

// *** bench/tape_controller_host_port_test.sv ***
// Testbench joining host controller and tape card over the common bus
`include "tape_port_params.svh"
module tape_controller_host_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0, card_strap = 8'h5a, tape_rd_data = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr, irq, tape_wr_valid, tape_wr_last, tape_rd_ready;
  logic [8:0]  tape_wr_data;
  logic        tape_wr_ready = 0, tape_rd_valid = 0, tape_rd_last = 0;
  logic [8:0]  wq[$];
  int          fail_count = 0, checks = 0, last_at = -1;
  logic [31:0] r;
  logic        e;
  io_bus_if i_io_bus_if ();
  tape_controller_card i_tape_controller_card (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .bus(i_io_bus_if.card), .card_strap(card_strap), .tape_wr_valid(tape_wr_valid),
    .tape_wr_data(tape_wr_data), .tape_wr_last(tape_wr_last), .tape_wr_ready(tape_wr_ready),
    .tape_rd_valid(tape_rd_valid), .tape_rd_data(tape_rd_data), .tape_rd_last(tape_rd_last),
    .tape_rd_ready(tape_rd_ready));
  io_controller_host #(.BYTE_CYCLES(4)) i_io_controller_host (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .bus(i_io_bus_if.host), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  tape_port_chk i_tape_port_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .addr(i_io_bus_if.addr), .card_strap(card_strap), .host_data_oe(i_io_bus_if.host_data_oe),
    .card_data_oe(i_io_bus_if.card_data_oe), .wr_strobe(i_io_bus_if.wr_strobe),
    .rd_strobe(i_io_bus_if.rd_strobe), .byte_valid_ack(i_io_bus_if.byte_valid_ack),
    .recv_ready(i_io_bus_if.recv_ready), .send_ready(i_io_bus_if.send_ready));
  always #5 clk_sys = ~clk_sys;
  // Tape unit stalls every other cycle and records what it accepts
  always @(posedge clk_sys) begin
    tape_wr_ready <= ~tape_wr_ready;
    if (tape_wr_valid === 1'b1 && tape_wr_ready === 1'b1) begin
      if (tape_wr_last === 1'b1) last_at = wq.size();
      wq.push_back(tape_wr_data);
    end
  end
  // ==========================================
  // Shared tasks
  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  task automatic timeout(input string nm);
    $display("mismatch %s expected done seen timeout", nm);
    fail_count++;
    finish_test();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 5000);
    if (n >= 5000) timeout("pready");
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic send_msg(input logic [7:0] ty, input int n, input logic [7:0] b, input int s);
    for (int i = s; i < `MSG_BYTES; i++)
      apb(1, `REG_TXDATA, (i == 0) ? ty : (i == 1) ? n : (i - 2 < n) ? b + i : 0);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs();
    apb(0, `REG_TARGET, 0); chk("target reset", `TARGET_RST, r);
    apb(1, `REG_TARGET, 32'h0000_5a00);
    apb(0, `REG_TARGET, 0); chk("target", 32'h0000_5a00, r);
    apb(1, `REG_STATUS, 32'h0000_0002);
    apb(0, `REG_STATUS, 0); chk("status", 32'h0000_0001, r);
    apb(0, 8'h20, 0); chk("slverr", 1, e);
    apb(0, `REG_INT_STAT, 0); chk("int stat", 32'h0000_0001, r);
    chk("irq masked", 0, irq);
    apb(1, `REG_INT_MASK, 32'h0000_0003);
    repeat (2) @(posedge clk_sys);
    chk("irq", 1, irq);
    apb(1, `REG_INT_STAT, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    chk("irq cleared", 0, irq);
  endtask
  task automatic t_write();
    card_strap <= 8'h3c;
    fork
      apb(1, `REG_TXDATA, `MSG_DATA);
      begin
        repeat (30) @(posedge clk_sys);
        chk("strobe", 1, i_io_bus_if.wr_strobe);
        chk("ack other card", 0, i_io_bus_if.byte_valid_ack);
        card_strap <= 8'h5a;
      end
    join
    send_msg(`MSG_DATA, 5, 8'h10, 1);
    send_msg(`MSG_DATA, 3, 8'h40, 0);
    send_msg(`MSG_END_REC, 0, 0, 0);
    for (int n = 0; wq.size() < 8; n++) begin
      if (n > 2000) timeout("tape write");
      @(posedge clk_sys);
    end
    for (int i = 0; i < 8; i++) begin
      logic [7:0] x;
      x = (i < 5) ? 8'h12 + i : 8'h42 + i - 5;
      chk("tape byte", {~^x, x}, wq[i]);
    end
    chk("tape last", 7, last_at);
  endtask
  task automatic t_read();
    send_msg(`MSG_XFER, 0, 0, 0);
    for (int n = 0; tape_rd_ready !== 1'b1; n++) begin
      if (n > 500) timeout("tape read");
      @(posedge clk_sys);
    end
    // Record two bytes longer than one block, so a second block is needed
    for (int i = 0; i < `MSG_BYTES + 2; i++) begin
      tape_rd_valid <= 1; tape_rd_data <= 8'(8'ha0 + i);
      tape_rd_last <= (i == `MSG_BYTES + 1);
      @(posedge clk_sys);
    end
    tape_rd_valid <= 0; tape_rd_last <= 0;
    for (int n = 0; i_io_bus_if.send_ready !== 1'b1; n++) begin
      if (n > 500) timeout("send ready");
      @(posedge clk_sys);
    end
    chk("recv low", 0, i_io_bus_if.recv_ready);
    for (int i = 0; i < 2 * `MSG_BYTES; i++) begin
      if (i == `MSG_BYTES) chk("send again", 1, i_io_bus_if.send_ready);
      apb(0, `REG_RXDATA, 0);
      chk("read byte", (i < `MSG_BYTES + 2) ? 8'(8'ha0 + i) : 8'h00, r[7:0]);
    end
    for (int n = 0; i_io_bus_if.recv_ready !== 1'b1; n++) begin
      if (n > 500) timeout("recv ready");
      @(posedge clk_sys);
    end
    chk("send after record", 0, i_io_bus_if.send_ready);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    chk("reset flags", 0, {i_io_bus_if.recv_ready, i_io_bus_if.send_ready});
    chk("reset ack", 0, i_io_bus_if.byte_valid_ack);
    repeat (2) @(posedge clk_sys);
    sys_rst <= 0;
    repeat (4) @(posedge clk_sys);
    chk("recv ready", 1, i_io_bus_if.recv_ready);
    t_regs();
    t_write();
    t_read();
    finish_test();
  end
endmodule
